// File: core/hrd_top.sv
// harmonic restraint decision and current magnitude unit, with register port
// assumes phasors and sample_tick come from upstream logic on sys_clk,
// stable while sample_tick is high; no synchroniser is needed on them
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module hrd_top #(
  parameter int TICK_US = 1000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sample_tick,
  input wire hrd_pkg::hrd_phasor_t phase1_fundamental_local,
  input wire hrd_pkg::hrd_phasor_t phase2_fundamental_local,
  input wire hrd_pkg::hrd_phasor_t phase3_fundamental_local,
  input wire hrd_pkg::hrd_phasor_t phase1_second_harm_local,
  input wire hrd_pkg::hrd_phasor_t phase2_second_harm_local,
  input wire hrd_pkg::hrd_phasor_t phase3_second_harm_local,
  input wire hrd_pkg::hrd_phasor_t phase1_fifth_harm_local,
  input wire hrd_pkg::hrd_phasor_t phase2_fifth_harm_local,
  input wire hrd_pkg::hrd_phasor_t phase3_fifth_harm_local,
  input wire hrd_pkg::hrd_phasor_t diff_current_phase1,
  input wire hrd_pkg::hrd_phasor_t diff_current_phase2,
  input wire hrd_pkg::hrd_phasor_t diff_current_phase3,
  input wire hrd_pkg::hrd_phasor_t local_shifted_phase1,
  input wire hrd_pkg::hrd_phasor_t local_shifted_phase2,
  input wire hrd_pkg::hrd_phasor_t local_shifted_phase3,
  input wire hrd_pkg::hrd_phasor_t remote_shifted_phase1,
  input wire hrd_pkg::hrd_phasor_t remote_shifted_phase2,
  input wire hrd_pkg::hrd_phasor_t remote_shifted_phase3,
  input wire logic [hrd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic h2_restraint_phase1,
  output logic h2_restraint_phase2,
  output logic h2_restraint_phase3,
  output logic h5_restraint_phase1,
  output logic h5_restraint_phase2,
  output logic h5_restraint_phase3,
  output logic h2_restraint_general,
  output logic h5_restraint_general,
  output logic diff_block,
  output logic [15:0] diff_magnitude_phase1,
  output logic [15:0] diff_magnitude_phase2,
  output logic [15:0] diff_magnitude_phase3,
  output logic [15:0] local_magnitude_phase1,
  output logic [15:0] local_magnitude_phase2,
  output logic [15:0] local_magnitude_phase3,
  output logic [15:0] remote_magnitude_phase1,
  output logic [15:0] remote_magnitude_phase2,
  output logic [15:0] remote_magnitude_phase3,
  output logic mag_valid,
  output logic irq
);
  typedef struct packed {
    hrd_pkg::hrd_mag_t mst;
    logic [3:0] ch;
    logic [4:0] it;
    logic [31:0] op;
    logic [31:0] res;
    logic [31:0] one;
    logic [hrd_pkg::NUM_MAG-1:0][31:0] sq;
    logic [hrd_pkg::NUM_MAG-1:0][15:0] mag;
    logic mag_valid;
    logic [hrd_pkg::THR_W-1:0] thr2;
    logic [hrd_pkg::THR_W-1:0] thr5;
    logic [hrd_pkg::IRQ_W-1:0] irq_st;
    logic [hrd_pkg::IRQ_W-1:0] irq_en;
    logic [5:0] flag_prev;
    logic [31:0] rdata;
  } hrd_top_st_t;

  hrd_top_st_t q;
  hrd_top_st_t d;
  hrd_pkg::hrd_phasor_t fund_a [3];
  hrd_pkg::hrd_phasor_t h2_a [3];
  hrd_pkg::hrd_phasor_t h5_a [3];
  hrd_pkg::hrd_phasor_t vec_a [hrd_pkg::NUM_MAG];
  logic [2:0] h2_flag;
  logic [2:0] h5_flag;
  logic [5:0] flags;
  logic [hrd_pkg::IRQ_W-1:0] ev;
  logic [hrd_pkg::IRQ_W-1:0] clr;
  logic [32:0] trial;

  ////////////////////////////////////////////////////////////////////////
  // per-phase input bundles; index 0..2 is phase 1..3
  assign fund_a[0] = phase1_fundamental_local;
  assign fund_a[1] = phase2_fundamental_local;
  assign fund_a[2] = phase3_fundamental_local;
  assign h2_a[0] = phase1_second_harm_local;
  assign h2_a[1] = phase2_second_harm_local;
  assign h2_a[2] = phase3_second_harm_local;
  assign h5_a[0] = phase1_fifth_harm_local;
  assign h5_a[1] = phase2_fifth_harm_local;
  assign h5_a[2] = phase3_fifth_harm_local;

  // magnitude channel order: differential, local, remote
  assign vec_a[0] = diff_current_phase1;
  assign vec_a[1] = diff_current_phase2;
  assign vec_a[2] = diff_current_phase3;
  assign vec_a[3] = local_shifted_phase1;
  assign vec_a[4] = local_shifted_phase2;
  assign vec_a[5] = local_shifted_phase3;
  assign vec_a[6] = remote_shifted_phase1;
  assign vec_a[7] = remote_shifted_phase2;
  assign vec_a[8] = remote_shifted_phase3;

  ////////////////////////////////////////////////////////////////////////
  // six independent deciders, each with its own timers
  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    hrd_restraint_unit #(
      .TICK_US(TICK_US)
    ) u_h2 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .tick(sample_tick),
      .fund(fund_a[p]),
      .harm(h2_a[p]),
      .thr_pct(q.thr2),
      .restraint(h2_flag[p])
    );
    hrd_restraint_unit #(
      .TICK_US(TICK_US)
    ) u_h5 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .tick(sample_tick),
      .fund(fund_a[p]),
      .harm(h5_a[p]),
      .thr_pct(q.thr5),
      .restraint(h5_flag[p])
    );
  end

  // per-phase outputs come straight from the deciders' state flops
  assign h2_restraint_phase1 = h2_flag[0];
  assign h2_restraint_phase2 = h2_flag[1];
  assign h2_restraint_phase3 = h2_flag[2];
  assign h5_restraint_phase1 = h5_flag[0];
  assign h5_restraint_phase2 = h5_flag[1];
  assign h5_restraint_phase3 = h5_flag[2];
  assign h2_restraint_general = |h2_flag;
  assign h5_restraint_general = |h5_flag;
  // over-excitation blocks as well as energizing inrush
  assign diff_block = h2_restraint_general | h5_restraint_general;
  assign flags = {h5_flag, h2_flag};

  ////////////////////////////////////////////////////////////////////////
  // events: rise of any restraint flag, and a finished magnitude set
  always_comb
  begin
    ev = {q.mag_valid, flags & ~q.flag_prev};
    clr = '0;
    if (reg_wr && reg_addr == hrd_pkg::REG_IRQ_CLR)
      clr = reg_wdata[hrd_pkg::IRQ_W-1:0];
  end

  // restoring root step; one spare bit keeps the trial sum from wrapping
  assign trial = {1'b0, q.res} + {1'b0, q.one};

  ////////////////////////////////////////////////////////////////////////
  // next state: register port, sticky status, magnitude engine
  always_comb
  begin
    d = q;
    d.mag_valid = 1'b0;
    d.flag_prev = flags;
    // set beats clear so an event in the clearing cycle survives
    d.irq_st = (q.irq_st & ~clr) | ev;
    if (reg_wr)
    begin
      case (reg_addr)
        hrd_pkg::REG_H2_THR: d.thr2 = reg_wdata[hrd_pkg::THR_W-1:0];
        hrd_pkg::REG_H5_THR: d.thr5 = reg_wdata[hrd_pkg::THR_W-1:0];
        hrd_pkg::REG_IRQ_EN: d.irq_en = reg_wdata[hrd_pkg::IRQ_W-1:0];
        default: d.thr2 = q.thr2;
      endcase
    end
    // read data live for exactly the cycle after the strobe
    d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        hrd_pkg::REG_H2_THR: d.rdata[hrd_pkg::THR_W-1:0] = q.thr2;
        hrd_pkg::REG_H5_THR: d.rdata[hrd_pkg::THR_W-1:0] = q.thr5;
        hrd_pkg::REG_FLAGS:
        begin
          d.rdata[hrd_pkg::FLG_H2_LSB +: 3] = h2_flag;
          d.rdata[hrd_pkg::FLG_H5_LSB +: 3] = h5_flag;
          d.rdata[hrd_pkg::FLG_H2_GEN] = h2_restraint_general;
          d.rdata[hrd_pkg::FLG_H5_GEN] = h5_restraint_general;
        end
        hrd_pkg::REG_IRQ_STAT: d.rdata[hrd_pkg::IRQ_W-1:0] = q.irq_st;
        hrd_pkg::REG_IRQ_EN: d.rdata[hrd_pkg::IRQ_W-1:0] = q.irq_en;
        default: d.rdata = '0;
      endcase
    end
    // one shared root engine; a tick while busy is skipped, and each
    // magnitude output takes its new value as soon as its own channel finishes
    case (q.mst)
      hrd_pkg::MAG_IDLE:
        if (sample_tick)
        begin
          for (int i = 0; i < hrd_pkg::NUM_MAG; i++)
            d.sq[i] = hrd_pkg::mag_sq(vec_a[i]);
          d.ch = '0;
          d.mst = hrd_pkg::MAG_LOAD;
        end
      hrd_pkg::MAG_LOAD:
      begin
        d.op = q.sq[q.ch];
        d.res = '0;
        d.one = hrd_pkg::SQRT_ONE;
        d.it = '0;
        d.mst = hrd_pkg::MAG_ITER;
      end
      hrd_pkg::MAG_ITER:
      begin
        if ({1'b0, q.op} >= trial)
        begin
          d.op = q.op - trial[31:0];
          d.res = (q.res >> 1) + q.one;
        end
        else
          d.res = q.res >> 1;
        d.one = q.one >> 2;
        d.it = q.it + 1'b1;
        if (q.it == hrd_pkg::SQRT_LAST)
        begin
          d.mag[q.ch] = d.res[15:0];
          if (q.ch == hrd_pkg::MAG_LAST)
          begin
            d.mag_valid = 1'b1;
            d.mst = hrd_pkg::MAG_IDLE;
          end
          else
          begin
            d.ch = q.ch + 1'b1;
            d.mst = hrd_pkg::MAG_LOAD;
          end
        end
      end
      default:
        d.mst = hrd_pkg::MAG_IDLE;
    endcase
  end

  // the whole block state in one register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.thr2 <= hrd_pkg::H2_THR_RST;
      q.thr5 <= hrd_pkg::H5_THR_RST;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs from flops
  assign reg_rdata = q.rdata;
  assign mag_valid = q.mag_valid;
  assign irq = |(q.irq_st & q.irq_en);
  assign diff_magnitude_phase1 = q.mag[0];
  assign diff_magnitude_phase2 = q.mag[1];
  assign diff_magnitude_phase3 = q.mag[2];
  assign local_magnitude_phase1 = q.mag[3];
  assign local_magnitude_phase2 = q.mag[4];
  assign local_magnitude_phase3 = q.mag[5];
  assign remote_magnitude_phase1 = q.mag[6];
  assign remote_magnitude_phase2 = q.mag[7];
  assign remote_magnitude_phase3 = q.mag[8];

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_h2_general_or: assert property (
    $rose(h2_restraint_phase2) |-> h2_restraint_general)
    else $error("phase flag not seen on general 2nd flag");
  a_h5_general_or: assert property (
    !h5_restraint_phase1 && !h5_restraint_phase2 && !h5_restraint_phase3
    |-> !h5_restraint_general)
    else $error("general 5th flag without a phase flag");
  a_energize_block: assert property (
    h2_restraint_general |-> diff_block)
    else $error("2nd harmonic restraint did not block");
  a_mag_latency: assert property (
    sample_tick && q.mst == hrd_pkg::MAG_IDLE |-> ##154 mag_valid)
    else $error("magnitude set not done in 154 cycles");
  a_mag_root_value: assert property (
    mag_valid |-> (34'(q.mag[0]) * 34'(q.mag[0]) <= 34'(q.sq[0]))
    && (34'(q.sq[0]) < (34'(q.mag[0]) + 34'd1) * (34'(q.mag[0]) + 34'd1)))
    else $error("differential magnitude not the integer root");
  a_thr_write: assert property (
    reg_wr && reg_addr == hrd_pkg::REG_H2_THR
    |=> q.thr2 == $past(reg_wdata[hrd_pkg::THR_W-1:0]))
    else $error("2nd harmonic threshold not written");
  a_irq_set_wins: assert property (
    $rose(h2_restraint_phase1) |=> q.irq_st[0])
    else $error("restraint event lost in status");

  c_both_general: cover property (h2_restraint_general && h5_restraint_general);
  c_irq_seen: cover property ($rose(irq));
  c_mag_done: cover property (mag_valid);
endmodule : hrd_top

// File: core/hrd_pkg.sv
// shared constants, carriers and helpers of the harmonic restraint decision
// assumes one 20 MHz clock and Fourier phasors from upstream filters on it
//
// Summary of operation
// - six independent restraint deciders run: 2nd and 5th harmonic for each phase.
// - each decider takes the fundamental and its own harmonic's local phasor of its phase.
// - each decider compares the harmonic-to-fundamental ratio with its threshold.
// - the threshold percent refers to the local fundamental of the same phase.
// - a ratio above threshold raises the restraint flag in the same step.
// - raising starts a 25 ms qualifying timer that arms the drop-off timer.
// - a qualified restraint stays set 15 ms after the ratio falls back.
// - the three phase flags per harmonic are ORed into a general flag.
// - six separate per-phase restraint outputs are provided.
// - nine magnitudes are computed: differential, local and remote per phase.
// - an active 2nd harmonic restraint blocks the differential operation.
package hrd_pkg;
  localparam int DW = 16;
  localparam int THR_W = 8;
  localparam int IRQ_W = 7;
  localparam int ADDR_W = 8;
  localparam logic [THR_W-1:0] H2_THR_RST = 8'h0F;
  localparam logic [THR_W-1:0] H5_THR_RST = 8'h19;
  localparam int QUAL_TIME_US = 25000;
  localparam int DROP_TIME_US = 15000;
  localparam logic [47:0] PCT_SQ = 48'h0000_0000_2710;
  // register map
  localparam logic [ADDR_W-1:0] REG_H2_THR = 8'h00;
  localparam logic [ADDR_W-1:0] REG_H5_THR = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h14;
  localparam int FLG_H2_LSB = 0;
  localparam int FLG_H5_LSB = 3;
  localparam int FLG_H2_GEN = 6;
  localparam int FLG_H5_GEN = 7;
  localparam int IRQ_MAG_BIT = 6;
  // square root engine
  localparam int NUM_MAG = 9;
  localparam logic [4:0] SQRT_LAST = 5'h0F;
  localparam logic [31:0] SQRT_ONE = 32'h4000_0000;
  localparam logic [3:0] MAG_LAST = 4'h8;

  typedef struct packed {
    logic signed [DW-1:0] re;
    logic signed [DW-1:0] im;
  } hrd_phasor_t;

  typedef enum logic [1:0] {RS_IDLE, RS_QUAL, RS_HELD, RS_DROP} hrd_rst_t;
  typedef enum logic [1:0] {MAG_IDLE, MAG_LOAD, MAG_ITER} hrd_mag_t;

  // squared magnitude of a phasor, exact in 32 bits
  function automatic logic [31:0] mag_sq(input hrd_phasor_t p);
    logic signed [31:0] a;
    logic signed [31:0] b;
    a = 32'(p.re) * 32'(p.re);
    b = 32'(p.im) * 32'(p.im);
    return 32'(a) + 32'(b);
  endfunction : mag_sq

  // least time in ticks, rounded up, never below one
  function automatic int ticks_up(input int time_us, input int tick_us);
    int t;
    t = (time_us + tick_us - 1) / tick_us;
    return (t < 1) ? 1 : t;
  endfunction : ticks_up
endpackage : hrd_pkg

// File: core/hrd_restraint_unit.sv
// one harmonic restraint decider for one phase and one harmonic order
// assumes tick is a one-cycle strobe marking new phasors on sys_clk
`timescale 1ns/1ps
module hrd_restraint_unit #(
  parameter int TICK_US = 1000,
  parameter int CNT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tick,
  input wire hrd_pkg::hrd_phasor_t fund,
  input wire hrd_pkg::hrd_phasor_t harm,
  input wire logic [hrd_pkg::THR_W-1:0] thr_pct,
  output logic restraint
);
  localparam int QUAL_TICKS = hrd_pkg::ticks_up(hrd_pkg::QUAL_TIME_US, TICK_US);
  localparam int DROP_TICKS = hrd_pkg::ticks_up(hrd_pkg::DROP_TIME_US, TICK_US);
  localparam logic [CNT_W-1:0] QUAL_LAST = CNT_W'(QUAL_TICKS - 1);
  localparam logic [CNT_W-1:0] DROP_LAST = CNT_W'(DROP_TICKS - 1);

  typedef struct packed {
    hrd_pkg::hrd_rst_t st;
    logic [CNT_W-1:0] cnt;
  } hrd_unit_st_t;

  hrd_unit_st_t q;
  hrd_unit_st_t d;
  logic [47:0] lhs;
  logic [47:0] rhs;
  logic high;

  ////////////////////////////////////////////////////////////////////////
  // squared compare avoids a divider and a root: 100^2*|H|^2 > T^2*|F|^2
  always_comb
  begin
    lhs = 48'(hrd_pkg::mag_sq(harm)) * hrd_pkg::PCT_SQ;
    rhs = 48'(16'(thr_pct) * 16'(thr_pct)) * 48'(hrd_pkg::mag_sq(fund));
    high = lhs > rhs;
  end

  // state only moves on evaluation ticks
  always_comb
  begin
    d = q;
    if (tick)
    begin
      case (q.st)
        hrd_pkg::RS_IDLE:
          if (high)
          begin
            d.st = hrd_pkg::RS_QUAL;
            d.cnt = '0;
          end
        hrd_pkg::RS_QUAL:
          if (!high)
          begin
            d.st = hrd_pkg::RS_IDLE;
            d.cnt = '0;
          end
          else if (q.cnt == QUAL_LAST)
          begin
            d.st = hrd_pkg::RS_HELD;
            d.cnt = '0;
          end
          else
            d.cnt = q.cnt + 1'b1;
        hrd_pkg::RS_HELD:
          if (!high)
          begin
            d.st = hrd_pkg::RS_DROP;
            d.cnt = '0;
          end
        hrd_pkg::RS_DROP:
          if (high)
          begin
            d.st = hrd_pkg::RS_HELD; // ratio back up: stay qualified
            d.cnt = '0;
          end
          else if (q.cnt == DROP_LAST)
          begin
            d.st = hrd_pkg::RS_IDLE;
            d.cnt = '0;
          end
          else
            d.cnt = q.cnt + 1'b1;
        default:
          d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign restraint = (q.st != hrd_pkg::RS_IDLE);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_rise_same_step: assert property (
    tick && high && q.st == hrd_pkg::RS_IDLE |=> restraint)
    else $error("restraint not raised on high ratio");
  a_low_stays_off: assert property (
    tick && !high && q.st == hrd_pkg::RS_IDLE |=> !restraint)
    else $error("restraint raised on low ratio");
  a_short_release: assert property (
    tick && !high && q.st == hrd_pkg::RS_QUAL |=> !restraint && q.cnt == '0)
    else $error("short restraint not released");
  a_qual_arm: assert property (
    tick && high && q.st == hrd_pkg::RS_QUAL && q.cnt == QUAL_LAST
    |=> q.st == hrd_pkg::RS_HELD)
    else $error("qualifying timer did not arm drop-off");
  a_drop_extend: assert property (
    tick && !high && q.st == hrd_pkg::RS_HELD |=> restraint && q.st == hrd_pkg::RS_DROP)
    else $error("qualified restraint not extended");
  a_drop_end: assert property (
    tick && !high && q.st == hrd_pkg::RS_DROP && q.cnt == DROP_LAST |=> !restraint)
    else $error("drop-off extension did not end");
  c_drop_seen: cover property (q.st == hrd_pkg::RS_DROP ##1 q.st == hrd_pkg::RS_IDLE);
endmodule : hrd_restraint_unit

// File: test/hrd_src_model.sv
// partner model: the upstream Fourier filter strobe of the restraint block
// assumes the block's sys_clk and rstn; the bench holds the phasors around each strobe
`timescale 1ns/1ps
module hrd_src_model #(
  parameter int GAP = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  output logic sample_tick
);
  logic [7:0] cnt_q;

  //////////////////////////////////////////////////////////////////////////
  // one-cycle strobe per sample set; a larger gap models a slower filter
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 8'h00;
      sample_tick <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == 8'(GAP - 1)) ? 8'h00 : cnt_q + 8'h01;
      sample_tick <= (cnt_q == 8'(GAP - 1));
    end
  end
endmodule : hrd_src_model

// File: test/tb.sv
// self-checking bench of the harmonic restraint block
// assumes the filter model sets the tick rate; the bench drives phasors and registers
`timescale 1ns/1ps
module tb;
  localparam int QUAL = 5;
  localparam int DROP = 3;
  // magnitudes worked out by hand as the floor of the root
  localparam int CRE [9] = '{3, -6, 0, 5, 1, 8, -20, 300, 2};
  localparam int CIM [9] = '{4, 8, -7, 12, 1, 15, 21, 400, 3};
  localparam int MEXP [9] = '{5, 10, 7, 13, 1, 17, 29, 500, 3};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic sample_tick;
  hrd_pkg::hrd_phasor_t fnd [3];
  hrd_pkg::hrd_phasor_t h2 [3];
  hrd_pkg::hrd_phasor_t h5 [3];
  hrd_pkg::hrd_phasor_t cur [9];
  wire [15:0] mg [9];
  wire [5:0] fl;
  wire h2g, h5g, diff_block, mag_valid, irq;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [31:0] reg_rdata;
  logic [31:0] d;
  int n_mismatch = 0;
  int total_checks = 0;

  always #25 sys_clk = ~sys_clk;

  hrd_src_model #(.GAP(8)) u_hrd_src_model (.sys_clk(sys_clk), .rstn(rstn),
    .sample_tick(sample_tick));

  hrd_top #(.TICK_US(5000)) u_hrd_top (.sys_clk(sys_clk), .rstn(rstn), .sample_tick(sample_tick),
    .phase1_fundamental_local(fnd[0]), .phase2_fundamental_local(fnd[1]),
    .phase3_fundamental_local(fnd[2]), .phase1_second_harm_local(h2[0]),
    .phase2_second_harm_local(h2[1]), .phase3_second_harm_local(h2[2]),
    .phase1_fifth_harm_local(h5[0]), .phase2_fifth_harm_local(h5[1]),
    .phase3_fifth_harm_local(h5[2]), .diff_current_phase1(cur[0]),
    .diff_current_phase2(cur[1]), .diff_current_phase3(cur[2]),
    .local_shifted_phase1(cur[3]), .local_shifted_phase2(cur[4]),
    .local_shifted_phase3(cur[5]), .remote_shifted_phase1(cur[6]),
    .remote_shifted_phase2(cur[7]), .remote_shifted_phase3(cur[8]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .h2_restraint_phase1(fl[0]), .h2_restraint_phase2(fl[1]),
    .h2_restraint_phase3(fl[2]), .h5_restraint_phase1(fl[3]), .h5_restraint_phase2(fl[4]),
    .h5_restraint_phase3(fl[5]), .h2_restraint_general(h2g), .h5_restraint_general(h5g),
    .diff_block(diff_block), .diff_magnitude_phase1(mg[0]), .diff_magnitude_phase2(mg[1]),
    .diff_magnitude_phase3(mg[2]), .local_magnitude_phase1(mg[3]),
    .local_magnitude_phase2(mg[4]), .local_magnitude_phase3(mg[5]),
    .remote_magnitude_phase1(mg[6]), .remote_magnitude_phase2(mg[7]),
    .remote_magnitude_phase3(mg[8]), .mag_valid(mag_valid), .irq(irq));

  //////////////////////////////////////////////////////////////////////////
  // shared helpers: compare, register cycles, tick wait, harmonic drive
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask : rd

  // waits for the edge that takes a tick, then lets the flag update land
  task automatic tk();
    do @(posedge sys_clk); while (sample_tick !== 1'b1);
    @(negedge sys_clk);
  endtask : tk

  task automatic setharm(input int b, input int v);
    @(posedge sys_clk);
    if (b < 3)
      h2[b] <= {16'(v), 16'h0000};
    else
      h5[b-3] <= {16'(v), 16'h0000};
  endtask : setharm

  task automatic expf(input logic [5:0] e);
    chk("phase flags", {26'h0, e}, {26'h0, fl});
    chk("general h2", {31'h0, |e[2:0]}, {31'h0, h2g});
    chk("general h5", {31'h0, |e[5:3]}, {31'h0, h5g});
    chk("block", {31'h0, |e}, {31'h0, diff_block});
  endtask : expf

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    rd(hrd_pkg::REG_H2_THR, d);
    chk("h2 thr reset", 32'h0000_000F, d);
    rd(hrd_pkg::REG_H5_THR, d);
    chk("h5 thr reset", 32'h0000_0019, d);
    rd(8'h20, d);
    chk("unmapped", 32'h0000_0000, d);
    wr(hrd_pkg::REG_H2_THR, 32'h0000_0032);
    rd(hrd_pkg::REG_H2_THR, d);
    chk("h2 thr write", 32'h0000_0032, d);
    wr(hrd_pkg::REG_FLAGS, 32'h0000_00FF);
    rd(hrd_pkg::REG_FLAGS, d);
    chk("flags read only", 32'h0000_0000, d);
    wr(hrd_pkg::REG_H2_THR, 32'h0000_000F);
    $display("test regs done");
  endtask : t_regs

  task automatic t_mag();
    int i;
    i = 0;
    // look between edges, never in the step that launches the pulse
    @(negedge sys_clk);
    while (mag_valid !== 1'b1 && i < 400)
    begin
      @(negedge sys_clk);
      i++;
    end
    chk("mag valid", 32'h1, {31'h0, mag_valid});
    for (int c = 0; c < 9; c++)
      chk("magnitude", 32'(MEXP[c]), {16'h0, mg[c]});
    $display("test magnitudes done");
  endtask : t_mag

  // nh high ticks, then low ticks; a long burst must be extended by the drop time
  task automatic t_hold(input int b, input int nh);
    logic [5:0] e;
    e = 6'h01 << b;
    tk();
    setharm(b, 60);
    repeat (nh)
    begin
      tk();
      expf(e);
    end
    setharm(b, 0);
    if (nh > QUAL)
      repeat (DROP)
      begin
        tk();
        expf(e);
      end
    tk();
    expf(6'h00);
    $display("test hold unit %0d high %0d done", b, nh);
  endtask : t_hold

  // exact ratio boundary, against the fundamental of the unit's own phase
  task automatic t_ratio();
    @(posedge sys_clk);
    fnd[1] <= {16'sd200, 16'sd0};
    tk();
    setharm(4, 50);
    tk();
    expf(6'h00);
    setharm(4, 51);
    tk();
    expf(6'h10);
    setharm(4, 0);
    wr(hrd_pkg::REG_H2_THR, 32'h0000_0005);
    setharm(2, 5);
    tk();
    expf(6'h00);
    setharm(2, 6);
    tk();
    expf(6'h04);
    setharm(2, 0);
    tk();
    expf(6'h00);
    wr(hrd_pkg::REG_H2_THR, 32'h0000_000F);
    $display("test ratio done");
  endtask : t_ratio

  task automatic t_irq();
    wr(hrd_pkg::REG_IRQ_CLR, 32'h0000_007F);
    wr(hrd_pkg::REG_IRQ_EN, 32'h0000_0001);
    tk();
    setharm(0, 60);
    tk();
    @(negedge sys_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(hrd_pkg::REG_IRQ_STAT, d);
    chk("irq status", 32'h0000_0001, d & 32'h0000_003F);
    setharm(0, 0);
    tk();
    wr(hrd_pkg::REG_IRQ_CLR, 32'h0000_0001);
    @(negedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(hrd_pkg::REG_IRQ_EN, 32'h0000_0000);
    setharm(0, 60);
    tk();
    @(negedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(hrd_pkg::REG_IRQ_STAT, d);
    chk("irq status masked", 32'h0000_0001, d & 32'h0000_003F);
    setharm(0, 0);
    tk();
    $display("test irq done");
  endtask : t_irq

  // a reset in mid-run must clear flags, outputs and status and restore thresholds
  task automatic t_reset();
    wr(hrd_pkg::REG_H5_THR, 32'h0000_0032);
    rd(hrd_pkg::REG_H5_THR, d);
    chk("h5 thr write", 32'h0000_0032, d);
    setharm(0, 60);
    tk();
    expf(6'h01);
    @(posedge sys_clk);
    rstn <= 1'b0;
    h2[0] <= 32'h0000_0000;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    expf(6'h00);
    chk("magnitude after reset", 32'h0, {16'h0, mg[0]});
    chk("irq after reset", 32'h0, {31'h0, irq});
    rd(hrd_pkg::REG_IRQ_STAT, d);
    chk("status after reset", 32'h0, d);
    rd(hrd_pkg::REG_H2_THR, d);
    chk("h2 thr after reset", 32'h0000_000F, d);
    rd(hrd_pkg::REG_H5_THR, d);
    chk("h5 thr after reset", 32'h0000_0019, d);
    $display("test reset done");
  endtask : t_reset

  //////////////////////////////////////////////////////////////////////////
  // verdict, main sequence and watchdog
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial
  begin
    for (int i = 0; i < 3; i++)
    begin
      fnd[i] = {16'sd100, 16'sd0};
      h2[i] = 32'h0000_0000;
      h5[i] = 32'h0000_0000;
    end
    for (int i = 0; i < 9; i++)
      cur[i] = {16'(CRE[i]), 16'(CIM[i])};
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_mag();
    for (int b = 0; b < 6; b++)
    begin
      t_hold(b, QUAL);
      t_hold(b, QUAL + 1);
    end
    t_ratio();
    t_irq();
    t_reset();
    conclude();
  end

  initial
  begin
    #(20000 * 50);
    n_mismatch++;
    $display("watchdog expired");
    conclude();
  end
endmodule : tb
